// ---- logic/cfr_filter_bank.v ----
// filter configuration register bank with classic wishbone slave and three reset classes
`timescale 1ns/10ps
`include "cfr_consts.vh"

// Operation
// - mask select 1 resets 0x05, kept on wake
// - mask select 0 resets 0x50, kept on wake
// - links two and one reset 0x11
// - other selects, enables, links reset to zero
// - id bytes undefined at power-on, otherwise kept
// - std id low bits 4,2 unimplemented
// - bank reads zero unless mode 1 or 2, except the mode register, which always reads
module cfr_filter_bank #(
    parameter ID_BYTES = 16
) (
    input  wire        clk,
    input  wire        rstn,
    input  wire        por_rstn,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    output wire        wb_err_o,
    output wire [1:0]  can_mode,
    output wire [63:0] link_bus,
    output wire [15:0] filter_enable_bus
);

    // rstn covers every reset class (power-on, brown-out, external pin, watchdog, instruction,
    // stack); wake-up from sleep is no reset at all, so every register simply keeps its value.
    // por_rstn is low only on power-on or brown-out and feeds the id-byte undefined state.

    reg  [7:0]  buffer_mode_select_ff;
    reg  [7:0]  mask_select_3_ff;
    reg  [7:0]  mask_select_2_ff;
    reg  [7:0]  mask_select_1_ff;
    reg  [7:0]  mask_select_0_ff;
    reg  [7:0]  data_byte_filter_length_ff;
    reg  [7:0]  filter_enable_1_ff;
    reg  [7:0]  filter_enable_0_ff;
    reg  [7:0]  link_ff [0:7];
    reg  [7:0]  id_mem [0:ID_BYTES-1];
    reg  [1:0]  mode_ff;
    reg         por_s1_ff;
    reg         por_s2_ff;
    reg  [7:0]  nxt_buffer_mode_select;
    reg  [7:0]  nxt_mask_select_3;
    reg  [7:0]  nxt_mask_select_2;
    reg  [7:0]  nxt_mask_select_1;
    reg  [7:0]  nxt_mask_select_0;
    reg  [7:0]  nxt_data_byte_filter_length;
    reg  [7:0]  nxt_filter_enable_1;
    reg  [7:0]  nxt_filter_enable_0;
    reg  [1:0]  nxt_mode;

    wire        req;
    wire        wr;
    wire        mode_on;
    wire        hit_link;
    wire        hit_id;
    wire [2:0]  link_idx;
    wire [3:0]  id_idx;
    wire [7:0]  id_mask;
    reg  [7:0]  nxt_rd;
    reg         nxt_hit;
    wire [ID_BYTES-1:0] id_written;
    wire        hit_buf_mode;
    wire        hit_mask_sel3;
    wire        hit_mask_sel2;
    wire        hit_mask_sel1;
    wire        hit_mask_sel0;
    wire        hit_dlen;
    wire        hit_fen1;
    wire        hit_fen0;
    wire        hit_ctrl;
    wire        we_buf_mode;
    wire        we_mask_sel3;
    wire        we_mask_sel2;
    wire        we_mask_sel1;
    wire        we_mask_sel0;
    wire        we_dlen;
    wire        we_fen1;
    wire        we_fen0;
    wire        we_ctrl;
    wire        we_link;
    wire        we_id;
    wire [7:0]  link_rd;
    wire [7:0]  id_rd;

    assign req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr       = req & wb_we_i & wb_sel_i[0];
    assign hit_link = (wb_adr_i >= `CFR_OFF_LINK_BASE) && (wb_adr_i < `CFR_OFF_ID_BASE);
    assign hit_id   = (wb_adr_i >= `CFR_OFF_ID_BASE) && (wb_adr_i <= `CFR_OFF_ID_LAST);
    assign link_idx = wb_adr_i[4:2];
    assign id_idx   = wb_adr_i[5:2];
    // every fourth id byte is a standard-id low byte with bits 4 and 2 absent
    assign id_mask  = (id_idx[1:0] == 2'h1) ? `CFR_SIDL_MASK : `CFR_EXT_MASK;
    assign mode_on  = (mode_ff == `CFR_MODE_ENH) || (mode_ff == `CFR_MODE_FIFO);
    assign wb_err_o = 1'b0;
    assign can_mode = mode_ff;
    assign filter_enable_bus = {filter_enable_1_ff, filter_enable_0_ff};

    // address decode shared by the write strobes and the read mux
    assign hit_buf_mode  = (wb_adr_i == `CFR_OFF_BUF_MODE);
    assign hit_mask_sel3 = (wb_adr_i == `CFR_OFF_MASK_SEL3);
    assign hit_mask_sel2 = (wb_adr_i == `CFR_OFF_MASK_SEL2);
    assign hit_mask_sel1 = (wb_adr_i == `CFR_OFF_MASK_SEL1);
    assign hit_mask_sel0 = (wb_adr_i == `CFR_OFF_MASK_SEL0);
    assign hit_dlen      = (wb_adr_i == `CFR_OFF_DLEN);
    assign hit_fen1      = (wb_adr_i == `CFR_OFF_FEN1);
    assign hit_fen0      = (wb_adr_i == `CFR_OFF_FEN0);
    assign hit_ctrl      = (wb_adr_i == `CFR_OFF_CTRL);

    // writes need sel[0]; an unmapped address raises no strobe at all
    assign we_buf_mode   = wr & hit_buf_mode;
    assign we_mask_sel3  = wr & hit_mask_sel3;
    assign we_mask_sel2  = wr & hit_mask_sel2;
    assign we_mask_sel1  = wr & hit_mask_sel1;
    assign we_mask_sel0  = wr & hit_mask_sel0;
    assign we_dlen       = wr & hit_dlen;
    assign we_fen1       = wr & hit_fen1;
    assign we_fen0       = wr & hit_fen0;
    assign we_ctrl       = wr & hit_ctrl;
    assign we_link       = wr & hit_link;
    assign we_id         = wr & hit_id;
    // read sources of the banked registers
    assign link_rd       = link_ff[link_idx];
    assign id_rd         = id_written[id_idx] ? (id_mem[id_idx] & id_mask) : 8'h00;

    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_link
            assign link_bus[g*8 +: 8] = link_ff[g];
            always @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    if (g == 1 || g == 2) begin
                        link_ff[g] <= `CFR_RST_LINK_PAIR;
                    end else begin
                        link_ff[g] <= `CFR_RST_LINK;
                    end
                end else if (we_link && link_idx == g) begin
                    link_ff[g] <= wb_dat_i[7:0];
                end
            end
        end
    endgenerate

    // power-on detect passes two flops before use; these flops see no reset, so a
    // warm reset leaves the power-on history alone
    always @(posedge clk) begin
        por_s1_ff <= por_rstn;
        por_s2_ff <= por_s1_ff;
    end

    // one written flag per id byte, cleared only while power-on is seen and never by
    // rstn, so id contents survive every other reset; an unwritten byte reads as zero
    generate
        for (g = 0; g < ID_BYTES; g = g + 1) begin : g_id_flag
            reg written_ff;
            assign id_written[g] = written_ff;
            always @(posedge clk) begin
                if (!por_s2_ff) begin
                    written_ff <= 1'b0;
                end else if (we_id && id_idx == g) begin
                    written_ff <= 1'b1;
                end
            end
        end
    endgenerate

    always @(posedge clk) begin
        if (we_id) begin
            id_mem[id_idx] <= wb_dat_i[7:0] & id_mask;
        end
    end

    // a register takes write data on its own strobe only; unimplemented bits are dropped
    always @* begin
        nxt_buffer_mode_select      = buffer_mode_select_ff;
        nxt_mask_select_3           = mask_select_3_ff;
        nxt_mask_select_2           = mask_select_2_ff;
        nxt_mask_select_1           = mask_select_1_ff;
        nxt_mask_select_0           = mask_select_0_ff;
        nxt_data_byte_filter_length = data_byte_filter_length_ff;
        nxt_filter_enable_1         = filter_enable_1_ff;
        nxt_filter_enable_0         = filter_enable_0_ff;
        nxt_mode                    = mode_ff;
        if (we_buf_mode) begin
            nxt_buffer_mode_select = wb_dat_i[7:0] & `CFR_BUF_MODE_MASK;
        end
        if (we_mask_sel3) begin
            nxt_mask_select_3 = wb_dat_i[7:0];
        end
        if (we_mask_sel2) begin
            nxt_mask_select_2 = wb_dat_i[7:0];
        end
        if (we_mask_sel1) begin
            nxt_mask_select_1 = wb_dat_i[7:0];
        end
        if (we_mask_sel0) begin
            nxt_mask_select_0 = wb_dat_i[7:0];
        end
        if (we_dlen) begin
            nxt_data_byte_filter_length = wb_dat_i[7:0] & `CFR_DLEN_MASK;
        end
        if (we_fen1) begin
            nxt_filter_enable_1 = wb_dat_i[7:0];
        end
        if (we_fen0) begin
            nxt_filter_enable_0 = wb_dat_i[7:0];
        end
        if (we_ctrl) begin
            nxt_mode = wb_dat_i[`CFR_CTRL_MODE_LSB +: `CFR_CTRL_MODE_W];
        end
    end

    // wake-up applies no reset, so every register below simply holds through it
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            buffer_mode_select_ff <= `CFR_RST_BUF_MODE;
        end else begin
            buffer_mode_select_ff <= nxt_buffer_mode_select;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mask_select_3_ff <= `CFR_RST_MASK_SEL3;
        end else begin
            mask_select_3_ff <= nxt_mask_select_3;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mask_select_2_ff <= `CFR_RST_MASK_SEL2;
        end else begin
            mask_select_2_ff <= nxt_mask_select_2;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mask_select_1_ff <= `CFR_RST_MASK_SEL1;
        end else begin
            mask_select_1_ff <= nxt_mask_select_1;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mask_select_0_ff <= `CFR_RST_MASK_SEL0;
        end else begin
            mask_select_0_ff <= nxt_mask_select_0;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            data_byte_filter_length_ff <= `CFR_RST_DLEN;
        end else begin
            data_byte_filter_length_ff <= nxt_data_byte_filter_length;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            filter_enable_1_ff <= `CFR_RST_FEN;
        end else begin
            filter_enable_1_ff <= nxt_filter_enable_1;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            filter_enable_0_ff <= `CFR_RST_FEN;
        end else begin
            filter_enable_0_ff <= nxt_filter_enable_0;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mode_ff <= `CFR_RST_CTRL;
        end else begin
            mode_ff <= nxt_mode;
        end
    end

    always @* begin
        nxt_rd  = 8'h00;
        nxt_hit = 1'b1;
        if (hit_buf_mode) begin
            nxt_rd = buffer_mode_select_ff;
        end else if (hit_mask_sel3) begin
            nxt_rd = mask_select_3_ff;
        end else if (hit_mask_sel2) begin
            nxt_rd = mask_select_2_ff;
        end else if (hit_mask_sel1) begin
            nxt_rd = mask_select_1_ff;
        end else if (hit_mask_sel0) begin
            nxt_rd = mask_select_0_ff;
        end else if (hit_dlen) begin
            nxt_rd = data_byte_filter_length_ff;
        end else if (hit_fen1) begin
            nxt_rd = filter_enable_1_ff;
        end else if (hit_fen0) begin
            nxt_rd = filter_enable_0_ff;
        end else if (hit_ctrl) begin
            nxt_rd = {6'h00, mode_ff};
        end else if (hit_link) begin
            nxt_rd = link_rd;
        end else if (hit_id) begin
            nxt_rd = id_rd;
        end else begin
            nxt_hit = 1'b0;
        end
        // the mode register itself stays visible so software can enable the bank
        if (nxt_hit && !mode_on && !hit_ctrl) begin
            nxt_rd = 8'h00;
        end
    end

    // one wait state: ack one edge after the request is seen, dropped the next edge
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    // read data stands until the next read is taken
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (req && !wb_we_i) begin
            wb_dat_o <= {24'h000000, nxt_rd};
        end
    end

endmodule

// ---- shared/cfr_consts.vh ----
// offsets, reset values and field layouts of the filter configuration register bank
`ifndef CFR_CONSTS_VH
`define CFR_CONSTS_VH

`define CFR_ADR_W              8
`define CFR_OFF_BUF_MODE       8'h00
`define CFR_OFF_MASK_SEL3      8'h04
`define CFR_OFF_MASK_SEL2      8'h08
`define CFR_OFF_MASK_SEL1      8'h0c
`define CFR_OFF_MASK_SEL0      8'h10
`define CFR_OFF_DLEN           8'h14
`define CFR_OFF_FEN1           8'h18
`define CFR_OFF_FEN0           8'h1c
`define CFR_OFF_LINK_BASE      8'h20
`define CFR_OFF_ID_BASE        8'h40
`define CFR_OFF_ID_LAST        8'h7c
`define CFR_OFF_CTRL           8'h80

`define CFR_RST_BUF_MODE       8'h00
`define CFR_RST_MASK_SEL3      8'h00
`define CFR_RST_MASK_SEL2      8'h00
`define CFR_RST_MASK_SEL1      8'h05
`define CFR_RST_MASK_SEL0      8'h50
`define CFR_RST_DLEN           8'h00
`define CFR_RST_FEN            8'h00
`define CFR_RST_LINK           8'h00
`define CFR_RST_LINK_PAIR      8'h11
`define CFR_RST_CTRL           2'h0

`define CFR_BUF_MODE_MASK      8'h3f
`define CFR_DLEN_MASK          8'h1f
`define CFR_SIDL_MASK          8'heb
`define CFR_EXT_MASK           8'hff

`define CFR_CTRL_MODE_LSB      0
`define CFR_CTRL_MODE_W        2
`define CFR_MODE_LEGACY        2'h0
`define CFR_MODE_ENH           2'h1
`define CFR_MODE_FIFO          2'h2

`define CFR_ID_FILTER_COUNT    4
`define CFR_ID_BYTES           16

`endif

// ---- testbench/cfr_filter_bank_asserts.sv ----
// bus timing and reset value assertions for the filter bank
`timescale 1ns/10ps
module cfr_filter_bank_asserts #(
    parameter ID_BYTES = 16
) (
    input wire        clk,
    input wire        rstn,
    input wire        por_rstn,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [7:0]  wb_adr_i,
    input wire [3:0]  wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    input wire        wb_err_o,
    input wire [1:0]  can_mode,
    input wire [63:0] link_bus,
    input wire [15:0] filter_enable_bus
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence req_taken;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence rd_ack;
        wb_ack_o && !wb_we_i;
    endsequence
    ack_timing_a: assert property (req_taken |=> wb_ack_o) else $error("ack late");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    err_low_a: assert property (!wb_err_o) else $error("err raised");
    upper_zero_a: assert property (rd_ack |-> wb_dat_o[31:8] == 24'h0) else $error("upper bits set");
    link_pair_a: assert property ($rose(rstn) |-> link_bus[23:8] == 16'h1111) else $error("link reset");
    zero_reset_a: assert property ($rose(rstn) |-> {link_bus[63:24], link_bus[7:0], filter_enable_bus} == 0)
        else $error("zero reset");
    mode_gate_a: assert property (rd_ack ##0 (wb_adr_i != 8'h80 && !(can_mode inside {2'h1, 2'h2}))
        |-> wb_dat_o == 32'h0) else $error("read not gated");
    sidl_gap_a: assert property (rd_ack ##0 (wb_adr_i[7:6] == 2'h1 && wb_adr_i[3:2] == 2'h1)
        |-> wb_dat_o[4] == 1'b0 && wb_dat_o[2] == 1'b0) else $error("sidl gap set");
endmodule
bind cfr_filter_bank cfr_filter_bank_asserts #(.ID_BYTES(ID_BYTES)) u_chk (.clk(clk), .rstn(rstn),
    .por_rstn(por_rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
    .can_mode(can_mode), .link_bus(link_bus), .filter_enable_bus(filter_enable_bus));

// ---- testbench/tb.sv ----
// self-checking bench for the filter configuration register bank
`timescale 1ns/10ps
module tb;
    logic        clk = 0;
    logic        rstn = 0;
    logic        por_rstn = 0;
    logic        cyc = 0, stb = 0, we = 0;
    logic [7:0]  adr = 0;
    logic [3:0]  sel = 0;
    logic [31:0] dat = 0;
    wire  [31:0] dat_o;
    wire         ack, err;
    wire  [1:0]  mode;
    wire  [63:0] links;
    wire  [15:0] fen;
    logic [7:0]  mdl [0:32];
    logic [31:0] q;
    int          n_mismatch = 0, total_checks = 0;
    cfr_filter_bank i_dut (.clk(clk), .rstn(rstn), .por_rstn(por_rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .wb_err_o(err), .can_mode(mode), .link_bus(links), .filter_enable_bus(fen));
    initial forever #2.5 clk = ~clk;
    task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // writable bits of register word i; words past the control register are unmapped
    function automatic logic [7:0] msk(int i);
        if (i == 0) return 8'h3f;
        if (i == 5) return 8'h1f;
        if (i >= 16 && i < 32 && i % 4 == 1) return 8'heb;
        if (i == 32) return 8'h03;
        return (i > 32) ? 8'h00 : 8'hff;
    endfunction
    function automatic logic [31:0] expv(int i);
        if (i > 32) return 0;
        if (i < 32 && !(mdl[32] inside {8'h01, 8'h02})) return 0;
        return {24'h0, mdl[i]};
    endfunction
    task xfer(input logic w, input int i, input logic [7:0] d, input logic s);
        int k;
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= 8'(i * 4);
        dat <= {24'h0, d};
        sel <= {3'h0, s};
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1);
        q = dat_o;
        chk("ack", k, 2);
        if (w && s && i <= 32) mdl[i] = d & msk(i);
        cyc <= 0;
        stb <= 0;
        @(posedge clk);
    endtask
    task sweep(input string nm);
        for (int i = 0; i < 34; i++) begin
            xfer(0, i, 0, 0);
            chk(nm, q, expv(i));
        end
        chk("mode", mode, mdl[32][1:0]);
        chk("links", links, {mdl[15], mdl[14], mdl[13], mdl[12], mdl[11], mdl[10], mdl[9], mdl[8]});
        chk("fen", fen, {mdl[6], mdl[7]});
        $display("test %s done", nm);
    endtask
    // id bytes survive every reset but power-on
    task rst(input logic por);
        rstn <= 0;
        por_rstn <= !por;
        repeat (2) @(posedge clk);
        rstn <= 1;
        repeat (2) @(posedge clk);
        por_rstn <= 1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 33; i++) if (por || i < 16 || i == 32) mdl[i] = 0;
        mdl[3] = 8'h05;
        mdl[4] = 8'h50;
        mdl[9] = 8'h11;
        mdl[10] = 8'h11;
    endtask
    initial begin
        void'($urandom(32'h8b1d));
        rst(1);
        xfer(1, 32, 8'h01, 1);
        sweep("por");
        for (int i = 0; i < 34; i++) xfer(1, i, 8'($urandom), 1);
        xfer(1, 32, 8'h02, 1);
        sweep("fill");
        xfer(1, 20, 8'h5a, 0);
        repeat (40) @(posedge clk);
        sweep("wake");
        rst(0);
        xfer(1, 32, 8'h01, 1);
        sweep("warm");
        for (int m = 0; m < 4; m++) begin
            xfer(1, 32, 8'(m), 1);
            sweep("mode");
        end
        rst(1);
        xfer(1, 32, 8'h02, 1);
        sweep("cold");
        conclude();
    end
    // the sequence needs about 1000 cycles; this allows twenty times that
    initial begin
        #100000;
        n_mismatch++;
        conclude();
    end
endmodule
